// ---- logic/angle_divider.sv ----
// Sequential signed divider that turns an accumulated rate sum into a delta angle word
`timescale 1ns/1ps
`default_nettype none

module angle_divider (
  input  wire logic        core_clk,
  input  wire logic        rstN,
  input  wire logic        clkEn,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [16:0] divisor,
  output logic             done_r,
  output logic [15:0]      quotient_r
);

  logic        busy_r;
  logic        neg_r;
  logic [5:0]  stepCnt_r;
  logic [16:0] rem_r;
  logic [31:0] quo_r;
  logic [16:0] divisor_r;
  logic [17:0] trial;
  logic        quoFits;

  // Trial subtraction of one restoring step
  assign trial   = {rem_r, quo_r[31]} - {1'b0, divisor_r};
  assign quoFits = (quo_r[31:15] == 17'h0_0000);

  ////////////////////////////////////////////////////////////////////////////
  // Divide magnitude, one bit per cycle
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      busy_r    <= 1'b0;
      neg_r     <= 1'b0;
      stepCnt_r <= 6'h00;
      rem_r     <= 17'h0_0000;
      quo_r     <= imu_out_pkg::SUM_ZERO;
      divisor_r <= 17'h0_0000;
    end else if (clkEn) begin
      if (start) begin
        busy_r    <= 1'b1;
        neg_r     <= dividend[31];
        stepCnt_r <= imu_out_pkg::DIV_STEPS;
        rem_r     <= 17'h0_0000;
        quo_r     <= dividend[31] ? (~dividend + 32'h0000_0001) : dividend;
        divisor_r <= divisor;
      end else if (busy_r && stepCnt_r != 6'h00) begin
        stepCnt_r <= stepCnt_r - 6'h01;
        if (!trial[17]) begin
          rem_r <= trial[16:0];
          quo_r <= {quo_r[30:0], 1'b1};
        end else begin
          rem_r <= {rem_r[15:0], quo_r[31]};
          quo_r <= {quo_r[30:0], 1'b0};
        end
      end else if (busy_r) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Signed, saturated result and completion pulse
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      done_r     <= 1'b0;
      quotient_r <= imu_out_pkg::WORD_ZERO;
    end else if (clkEn) begin
      done_r <= busy_r && stepCnt_r == 6'h00 && !start;
      if (busy_r && stepCnt_r == 6'h00 && !start) begin
        if (!neg_r) begin
          quotient_r <= quoFits ? quo_r[15:0] : imu_out_pkg::ROT_POS_LIMIT;
        end else if (quo_r[31:15] == 17'h0_0000 || quo_r == 32'h0000_8000) begin
          quotient_r <= ~quo_r[15:0] + 16'h0001;
        end else begin
          quotient_r <= imu_out_pkg::ROT_NEG_LIMIT;
        end
      end
    end
  end

  // Fixed latency from start to result
  chk_div_latency: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    start && !busy_r |-> ##34 done_r) else $error("divider result late or early"); // [R1]
  // Zero sum reports zero displacement
  chk_zero_angle: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    start && !busy_r && dividend == 32'h0 |-> ##34 quotient_r == 16'h0000)
    else $error("zero sum gave nonzero angle"); // [R3]

endmodule : angle_divider

`default_nettype wire

// ---- logic/imu_out_pkg.sv ----
// Package: offsets, timing constants and carrier types of the output data registers
package imu_out_pkg;

  // Register byte offsets (lower byte of each two-byte register)
  localparam logic [6:0] OFF_ACCEL_X_LOW  = 7'h10;
  localparam logic [6:0] OFF_ACCEL_X_HIGH = 7'h12;
  localparam logic [6:0] OFF_ACCEL_Y_LOW  = 7'h14;
  localparam logic [6:0] OFF_ACCEL_Y_HIGH = 7'h16;
  localparam logic [6:0] OFF_ACCEL_Z_LOW  = 7'h18;
  localparam logic [6:0] OFF_ACCEL_Z_HIGH = 7'h1a;
  localparam logic [6:0] OFF_ROT_X        = 7'h24;
  localparam logic [6:0] OFF_ROT_Y        = 7'h26;
  localparam logic [6:0] OFF_ROT_Z        = 7'h28;

  // Field widths and positions
  localparam int ADDR_W        = 7;
  localparam int WORD_W        = 16;
  localparam int SUM_W         = 32;
  localparam int DIV_W         = 17;
  localparam int CLK_SEL_LSB   = 2;   // Sample clock select field [3:2]
  localparam int HIGH_BYTE_LSB = 8;

  // Reset and encoding values
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [31:0] SUM_ZERO      = 32'h0000_0000;
  localparam logic [1:0]  SEL_INTERNAL  = 2'h0;
  localparam logic [15:0] ROT_POS_LIMIT = 16'h7fff;
  localparam logic [15:0] ROT_NEG_LIMIT = 16'h8000;

  // Timing: internal sample rate and core clock
  localparam int CLK_HZ           = 125_000_000;
  localparam int INT_SAMPLE_HZ    = 2048;
  localparam int INT_TICK_CYCLES  = CLK_HZ / INT_SAMPLE_HZ;  // Rounded down
  localparam logic [5:0] DIV_STEPS = 6'h20;                  // One step per dividend bit

  // Carrier types
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } axis_word_t;

  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] z;
  } axis_wide_t;

endpackage : imu_out_pkg

// ---- logic/inertial_output_data_regs.sv ----
// Output data registers: delta angle accumulation and paired acceleration words
//
// What this block does
// R1 - Delta angle per axis is displacement accumulated over one processing cycle.
// R2 - Delta angle words read only at 0x24 (x), 0x26 (y), 0x28 (z).
// R3 - Delta angle is 16-bit two's complement; zero displacement reads 0x0000.
// R4 - Delta angle LSB equals 0.005 deg/s times (decimation plus one) over sample rate.
// R5 - Select field 00 uses internal 2048 Hz; other values use the external clock.
// R6 - Six read-only acceleration words; x secondary at 0x10, primary at 0x12.
// R7 - Y secondary at 0x14, y primary at 0x16, z secondary at 0x18.
// R8 - Primary acceleration word is 16-bit two's complement at 0.25 mg per LSB.
// R9 - Secondary word carries extra low-order resolution from filter summation.
// R10 - Primary above secondary forms a signed result of up to 32 bits.
// R11 - Z primary acceleration word read only at 0x1A, same format as others.
// R12 - Each register spans two bytes; upper byte sits at lower address plus one.
// R13 - Both halves of one axis update together from the same processing cycle.
`timescale 1ns/1ps
`default_nettype none

module inertial_output_data_regs #(
  parameter int INT_TICK_CYCLES = imu_out_pkg::INT_TICK_CYCLES
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clkEn,
  input  wire logic                   extSampleClk,
  input  wire logic [3:0]             misc_control_word,
  input  wire logic [15:0]            decimation_setting,
  input  wire imu_out_pkg::axis_word_t gyroRateIn,
  input  wire imu_out_pkg::axis_wide_t accelIn,
  input  wire logic                   rdEn,
  input  wire logic [6:0]             rdAddr,
  output logic                        rdValid_r,
  output logic [15:0]                 rdData_r,
  output logic                        cycleDone_r
);

  typedef enum logic {PH_ACCUM, PH_DIVIDE} phase_t;

  logic                    rstSync1_r;
  logic                    rstN;
  logic                    ext1_r;
  logic                    ext2_r;
  logic                    ext3_r;
  logic                    extRise;
  logic [31:0]             intCnt_r;
  logic                    intTick;
  logic                    sampleTick;
  logic [15:0]             decCnt_r;
  logic                    cycleEnd;
  phase_t                  phase_r;
  imu_out_pkg::axis_wide_t angSum_r;
  imu_out_pkg::axis_wide_t angTotal;
  imu_out_pkg::axis_wide_t accelWord_r;
  imu_out_pkg::axis_word_t rotWord_r;
  imu_out_pkg::axis_word_t quotient;
  logic [2:0]              divDone;
  logic [16:0]             divisor;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_r <= 1'b0;
      rstN       <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstN       <= rstSync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External sample clock: two-stage synchroniser, then edge detect
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ext1_r <= 1'b0;
      ext2_r <= 1'b0;
      ext3_r <= 1'b0;
    end else if (clkEn) begin
      ext1_r <= extSampleClk;
      ext2_r <= ext1_r;
      ext3_r <= ext2_r;
    end
  end

  assign extRise = ext2_r && !ext3_r;

  // Internal sample tick generator
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      intCnt_r <= 32'h0000_0000;
    end else if (clkEn) begin
      intCnt_r <= intTick ? 32'h0000_0000 : intCnt_r + 32'h0000_0001;
    end
  end

  assign intTick = (intCnt_r == 32'(INT_TICK_CYCLES - 1));

  // Sample source chosen by the clock select field
  assign sampleTick = (misc_control_word[imu_out_pkg::CLK_SEL_LSB +: 2]
                       == imu_out_pkg::SEL_INTERNAL) ? intTick : extRise;  // [R5]

  ////////////////////////////////////////////////////////////////////////////
  // Decimation counter: one processing cycle is setting plus one samples
  assign cycleEnd = sampleTick && (decCnt_r == decimation_setting);  // [R4]
  assign divisor  = {1'b0, decimation_setting} + 17'h0_0001;         // [R4]

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      decCnt_r <= imu_out_pkg::WORD_ZERO;
    end else if (clkEn && sampleTick) begin
      decCnt_r <= cycleEnd ? imu_out_pkg::WORD_ZERO : decCnt_r + 16'h0001;
    end
  end

  // Running rate sum including the current sample
  assign angTotal.x = angSum_r.x + {{16{gyroRateIn.x[15]}}, gyroRateIn.x};
  assign angTotal.y = angSum_r.y + {{16{gyroRateIn.y[15]}}, gyroRateIn.y};
  assign angTotal.z = angSum_r.z + {{16{gyroRateIn.z[15]}}, gyroRateIn.z};

  // Accumulate rate over the cycle, restart at its end
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      angSum_r <= '0;
    end else if (clkEn && sampleTick) begin
      angSum_r <= cycleEnd ? '0 : angTotal;  // [R1]
    end
  end

  // Phase tracking between accumulation and division
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      phase_r <= PH_ACCUM;
    end else if (clkEn) begin
      case (phase_r)
        PH_ACCUM:  if (cycleEnd) phase_r <= PH_DIVIDE;
        PH_DIVIDE: if (divDone[0]) phase_r <= PH_ACCUM;
        default:   phase_r <= PH_ACCUM;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sum over (setting plus one) samples divided by (setting plus one)
  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_axis
      angle_divider u_div (
        .core_clk   (core_clk),
        .rstN       (rstN),
        .clkEn      (clkEn),
        .start      (cycleEnd && phase_r == PH_ACCUM),
        .dividend   (angTotal[ax*32 +: 32]),
        .divisor    (divisor),
        .done_r     (divDone[ax]),
        .quotient_r (quotient[ax*16 +: 16])
      );
    end
  endgenerate

  // Delta angle words refresh once per processing cycle
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      rotWord_r   <= '0;
      cycleDone_r <= 1'b0;
    end else if (clkEn) begin
      cycleDone_r <= divDone[0];
      if (divDone[0]) begin
        rotWord_r <= quotient;  // [R1] [R3]
      end
    end
  end

  // Both acceleration halves latched in one edge
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      accelWord_r <= '0;
    end else if (clkEn && cycleEnd) begin
      accelWord_r <= accelIn;  // [R9] [R10] [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode
  function automatic logic [15:0] regWord(input logic [6:0] a,
                                          input imu_out_pkg::axis_wide_t acc,
                                          input imu_out_pkg::axis_word_t rot);
    logic [15:0] w;
    w = imu_out_pkg::WORD_ZERO;
    case ({a[6:1], 1'b0})
      imu_out_pkg::OFF_ACCEL_X_LOW:  w = acc.x[15:0];   // [R6] [R9]
      imu_out_pkg::OFF_ACCEL_X_HIGH: w = acc.x[31:16];  // [R6] [R8]
      imu_out_pkg::OFF_ACCEL_Y_LOW:  w = acc.y[15:0];   // [R7]
      imu_out_pkg::OFF_ACCEL_Y_HIGH: w = acc.y[31:16];  // [R7]
      imu_out_pkg::OFF_ACCEL_Z_LOW:  w = acc.z[15:0];   // [R7]
      imu_out_pkg::OFF_ACCEL_Z_HIGH: w = acc.z[31:16];  // [R11]
      imu_out_pkg::OFF_ROT_X:        w = rot.x;         // [R2]
      imu_out_pkg::OFF_ROT_Y:        w = rot.y;         // [R2]
      imu_out_pkg::OFF_ROT_Z:        w = rot.z;         // [R2]
      default:                       w = imu_out_pkg::WORD_ZERO;
    endcase
    // Odd address returns the upper byte alone
    if (a[0]) begin
      w = {8'h00, w[15:imu_out_pkg::HIGH_BYTE_LSB]};  // [R12]
    end
    return w;
  endfunction : regWord

  // Registered read answer, one cycle after the request
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      rdValid_r <= 1'b0;
      rdData_r  <= imu_out_pkg::WORD_ZERO;
    end else if (clkEn) begin
      rdValid_r <= rdEn;
      if (rdEn) begin
        rdData_r <= regWord(rdAddr, accelWord_r, rotWord_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_rot_refresh: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    divDone[0] |=> rotWord_r == $past(quotient)) else $error("angle word not refreshed"); // [R1]
  chk_cycle_len: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    sampleTick && !cycleEnd |=> decCnt_r == $past(decCnt_r) + 16'h0001)
    else $error("sample count did not advance"); // [R4]
  chk_tick_source: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    sampleTick |-> (misc_control_word[3:2] == 2'b00 ? intTick : extRise))
    else $error("wrong sample source"); // [R5]
  chk_read_rot: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    rdEn && rdAddr == 7'h26 |=> rdValid_r && rdData_r == $past(rotWord_r.y))
    else $error("y angle read mismatch"); // [R2]
  chk_read_accx: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    rdEn && rdAddr == 7'h12 |=> rdData_r == $past(accelWord_r.x[31:16]))
    else $error("x primary read mismatch"); // [R6]
  chk_read_accz: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    rdEn && rdAddr == 7'h1a |=> rdData_r == $past(accelWord_r.z[31:16]))
    else $error("z primary read mismatch"); // [R11]
  chk_read_accy_low: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    rdEn && rdAddr == 7'h14 |=> rdData_r == $past(accelWord_r.y[15:0]))
    else $error("y secondary read mismatch"); // [R7]
  chk_upper_byte: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    rdEn && rdAddr == 7'h25 |=> rdData_r == {8'h00, $past(rotWord_r.x[15:8])})
    else $error("upper byte read mismatch"); // [R12]
  chk_accel_pair: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    cycleEnd |=> accelWord_r == $past(accelIn)) else $error("halves not latched together"); // [R13]
  chk_unmapped: assert property (@(posedge core_clk) disable iff (!rstN || !clkEn)
    rdEn && rdAddr == 7'h30 |=> rdData_r == 16'h0000) else $error("unmapped read nonzero"); // [R10]

  cov_ext_cycle: cover property (@(posedge core_clk) disable iff (!rstN)
    cycleEnd && misc_control_word[3:2] != 2'b00);
  cov_int_cycle: cover property (@(posedge core_clk) disable iff (!rstN)
    cycleEnd && misc_control_word[3:2] == 2'b00);
  cov_neg_angle: cover property (@(posedge core_clk) disable iff (!rstN)
    divDone[0] && quotient.x[15]);
  cov_read_rot: cover property (@(posedge core_clk) disable iff (!rstN)
    rdEn && rdAddr == 7'h28);

endmodule : inertial_output_data_regs

`default_nettype wire

// ---- tb/host_model.sv ----
// Host side model: issues register reads on the read port and returns the answer
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic        core_clk,
  output logic             rdEn,
  output logic [6:0]       rdAddr,
  input  wire logic        rdValid_r,
  input  wire logic [15:0] rdData_r
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle request lines at time zero
  initial begin
    rdEn = 1'b0;
    rdAddr = 7'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One read of a two-byte register or of its upper byte alone
  task automatic read_word(input logic [6:0] addr, output logic [15:0] data,
                           output logic ok);
    @(negedge core_clk);
    rdEn = 1'b1;
    rdAddr = addr;
    @(negedge core_clk);
    rdEn = 1'b0;
    rdAddr = ~addr;  // Released address shows a changed pattern
    ok = rdValid_r;
    data = rdData_r;
  endtask : read_word
endmodule : host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Testbench: reads the output data registers and judges them against expected values
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int TICK = 50;
  logic                    core_clk;
  logic                    rst_n;
  logic                    clkEn;
  logic                    extSampleClk;
  logic                    extRun;
  logic [3:0]              selWord;
  logic [15:0]             decim;
  imu_out_pkg::axis_word_t gyro;
  imu_out_pkg::axis_wide_t accel;
  logic                    rdEn;
  logic [6:0]              rdAddr;
  logic                    rdValid_r;
  logic [15:0]             rdData_r;
  logic                    cycleDone_r;
  int                      err_count = 0;
  int                      comparisons = 0;
  int                      extCnt = 0;

  inertial_output_data_regs #(.INT_TICK_CYCLES(TICK)) inertial_output_data_regs_i (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .extSampleClk(extSampleClk),
    .misc_control_word(selWord), .decimation_setting(decim), .gyroRateIn(gyro),
    .accelIn(accel), .rdEn(rdEn), .rdAddr(rdAddr), .rdValid_r(rdValid_r),
    .rdData_r(rdData_r), .cycleDone_r(cycleDone_r));

  host_model host_model_i (
    .core_clk(core_clk), .rdEn(rdEn), .rdAddr(rdAddr), .rdValid_r(rdValid_r),
    .rdData_r(rdData_r));

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // External sample clock, 80 core cycles a period, still while not running
  always @(negedge core_clk) begin
    if (extRun) begin
      extCnt <= (extCnt == 39) ? 0 : extCnt + 1;
      if (extCnt == 39) extSampleClk <= ~extSampleClk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Compare of one 16-bit result
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk16

  // Register read with answer check
  task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host_model_i.read_word(addr, d, ok);
    chk16({15'h0000, ok}, 16'h0001);
    chk16(d, exp);
  endtask : rd_chk

  // Bounded wait for the end of a processing cycle; n counts cycles waited
  task automatic wait_done(input logic must, output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (cycleDone_r !== 1'b1 && n < 600);
    if (must && n >= 600) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
      err_count++;
      end_of_test();
    end
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////////////
  // All words zero after reset, unmapped and odd places too
  task automatic test_reset();
    logic [6:0] addrs [12] = '{7'h10, 7'h12, 7'h14, 7'h16, 7'h18, 7'h1a, 7'h24,
                               7'h26, 7'h28, 7'h20, 7'h25, 7'h30};
    foreach (addrs[i]) rd_chk(addrs[i], 16'h0000);
    $display("test reset done");
  endtask : test_reset

  // Acceleration halves latched together at cycle end
  task automatic test_accel();
    int n;
    accel = {32'h4e20_8001, 32'hb1e0_0003, 32'hffff_fffe};
    wait_done(1'b1, n);
    wait_done(1'b1, n);
    accel = {32'h1111_2222, 32'h3333_4444, 32'h5555_6666};
    rd_chk(7'h10, 16'h8001);
    rd_chk(7'h12, 16'h4e20);
    rd_chk(7'h14, 16'h0003);
    rd_chk(7'h16, 16'hb1e0);
    rd_chk(7'h18, 16'hfffe);
    rd_chk(7'h1a, 16'hffff);
    rd_chk(7'h13, 16'h004e);
    rd_chk(7'h17, 16'h00b1);
    $display("test accel done");
  endtask : test_accel

  // Delta angle on internal ticks, four samples a cycle
  task automatic test_angle_int();
    int n;
    selWord = 4'h0;
    decim = 16'h0003;
    gyro = {16'h0100, 16'hff00, 16'h0000};
    wait_done(1'b1, n);
    wait_done(1'b1, n);
    chk16(16'(n), 16'h00c8);
    rd_chk(7'h24, 16'h0100);
    rd_chk(7'h26, 16'hff00);
    rd_chk(7'h28, 16'h0000);
    rd_chk(7'h29, 16'h0000);
    $display("test angle internal done");
  endtask : test_angle_int

  // Clock enable low freezes the tick chain and the read port
  task automatic test_freeze();
    int          n;
    logic [15:0] d;
    logic        ok;
    @(negedge core_clk);
    clkEn = 1'b0;
    wait_done(1'b0, n);
    chk16(16'(n), 16'h0258);
    host_model_i.read_word(7'h24, d, ok);
    chk16({15'h0000, ok}, 16'h0000);
    clkEn = 1'b1;
    wait_done(1'b1, n);
    rd_chk(7'h24, 16'h0100);
    $display("test freeze done");
  endtask : test_freeze

  // Delta angle on external ticks for every external select code
  task automatic test_angle_ext();
    logic [3:0] sels [3] = '{4'h4, 4'h8, 4'hc};
    int n;
    decim = 16'h0001;
    gyro = {16'hfffd, 16'h7fff, 16'h8000};
    extRun = 1'b1;
    foreach (sels[i]) begin
      selWord = sels[i];
      wait_done(1'b1, n);
      wait_done(1'b1, n);
      chk16(16'(n), 16'h00a0);
    end
    rd_chk(7'h24, 16'hfffd);
    rd_chk(7'h26, 16'h7fff);
    rd_chk(7'h28, 16'h8000);
    rd_chk(7'h27, 16'h007f);
    extRun = 1'b0;
    wait_done(1'b0, n);
    chk16(16'(n), 16'h0258);
    $display("test angle external done");
  endtask : test_angle_ext

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    extSampleClk = 1'b0;
    extRun = 1'b0;
    selWord = 4'h0;
    decim = 16'h0000;
    gyro = '0;
    accel = '0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    test_reset();
    test_accel();
    test_angle_int();
    test_freeze();
    test_angle_ext();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
